// >>> src/drs_regs.sv
// Rate select, link status, revision and legacy gain registers of the DAA system side
//
// What this block does
// [R1] Three-bit select picks one of seven rates
// [R2] Link failure sets sticky error bit seven
// [R3] Read-only bit six shows frame lock
// [R4] Off-hook loop current has two sense exceptions
// [R5] On-hook loop current is upper sense bits
// [R6] System-side revision read-only in bits 3:0
// [R7] Line-side revision read-only in bits 5:2
// [R8] Read-only capability bit at position six
// [R9] Legacy receive gain bit adds 6 dB
// [R10] Legacy transmit bit attenuates 3 dB
// [R11] Software keeps legacy transmit bit at zero
// [R12] Software keeps legacy receive bit at zero
// [R13] Reserved registers and bits read zero
// [R14] Only a written zero clears the error
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "drs_defines.svh"
module drs_regs
   import drs_pkg::*;
#(
   parameter logic [3:0] SYS_REV = `DRS_SYS_REV_VALUE // Arbitrary revision value
) (
   input wire logic clk, // 25 MHz block clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic [3:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   input wire logic link_fail, // Link failure pulse, same domain
   input wire logic frame_lock_pin, // Frame lock level from link
   input wire logic [4:0] line_sense_field, // Line sense from line side
   input wire logic off_hook, // Off-hook state, same domain
   input wire logic [3:0] line_side_rev, // Line-side chip revision
   input wire logic line_side_capability, // Line-side capability bit
   output logic [2:0] rate_select, // Chosen sample rate code
   output logic rate_valid, // Rate code is not reserved
   output logic legacy_rx_gain, // 6 dB receive gain enable
   output logic legacy_tx_atten, // 3 dB transmit attenuation enable
   output logic link_error // Sticky link error flag
);
   logic [2:0] rate_q; // Rate select register
   logic rx_gain_q; // Legacy receive gain register
   logic tx_atten_q; // Legacy transmit attenuation register
   logic link_err_q; // Sticky error flag
   logic frame_lock_flag; // Synchronised frame lock
   logic [3:0] loop_current_value; // Decoded loop current
   logic [7:0] rdata_d; // Read mux result
   logic wr_rate; // Write hit on rate register
   logic wr_stat; // Write hit on status register
   logic wr_gain; // Write hit on gain register

   // Frame lock comes across the link boundary
   drs_sync u_lock_sync (
      .clk(clk),
      .resetn(resetn),
      .async_in(frame_lock_pin),
      .sync_out(frame_lock_flag)
   );

   // Loop current decode
   drs_loop_decode u_loop (
      .sense(line_sense_field),
      .off_hook(off_hook),
      .loop_current(loop_current_value)
   );

   // Address decode for writes
   assign wr_rate = reg_wr && (reg_addr == `DRS_OFF_RATE);
   assign wr_stat = reg_wr && (reg_addr == `DRS_OFF_LINE_STAT);
   assign wr_gain = reg_wr && (reg_addr == `DRS_OFF_LINE_REV);

   // Rate select register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rate_q <= `DRS_RATE_RESET;
      end else if (wr_rate) begin
         rate_q <= reg_wdata[2:0]; // [R1]
      end
   end

   // Rate outputs, reserved code flagged
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rate_select <= `DRS_RATE_RESET;
         rate_valid <= 1'b1;
      end else begin
         rate_select <= rate_q; // [R1]
         rate_valid <= (drs_rate_t'(rate_q) != DRS_RATE_RSVD); // [R1]
      end
   end

   // Legacy gain bits; software is expected to leave them at zero
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_gain_q <= 1'b0;
         tx_atten_q <= 1'b0;
      end else if (wr_gain) begin
         rx_gain_q <= reg_wdata[`DRS_BIT_RX_GAIN]; // [R9] [R12]
         tx_atten_q <= reg_wdata[`DRS_BIT_TX_ATTEN]; // [R10] [R11]
      end
   end

   // Gain controls driven to the analog paths
   always_ff @(posedge clk) begin
      if (!resetn) begin
         legacy_rx_gain <= 1'b0;
         legacy_tx_atten <= 1'b0;
      end else begin
         legacy_rx_gain <= rx_gain_q; // [R9]
         legacy_tx_atten <= tx_atten_q; // [R10]
      end
   end

   // Sticky error; failure wins over a clearing write
   always_ff @(posedge clk) begin
      if (!resetn) begin
         link_err_q <= 1'b0;
      end else if (link_fail) begin
         link_err_q <= 1'b1; // [R2]
      end else if (wr_stat && !reg_wdata[`DRS_BIT_LINK_ERR]) begin
         link_err_q <= 1'b0; // [R14]
      end
   end

   // Error flag output
   always_ff @(posedge clk) begin
      if (!resetn) begin
         link_error <= 1'b0;
      end else begin
         link_error <= link_err_q; // [R2]
      end
   end

   // Read mux; unmapped and reserved locations return zero
   always_comb begin
      rdata_d = 8'h00; // [R13]
      unique case (reg_addr)
         `DRS_OFF_RATE: begin
            rdata_d[2:0] = rate_q; // [R1]
         end
         `DRS_OFF_SYS_REV: begin
            rdata_d[3:0] = SYS_REV; // [R6]
         end
         `DRS_OFF_LINE_STAT: begin
            rdata_d[`DRS_BIT_LINK_ERR] = link_err_q; // [R2]
            rdata_d[`DRS_BIT_FRAME_LOCK] = frame_lock_flag; // [R3]
            rdata_d[3:0] = loop_current_value; // [R4] [R5]
         end
         `DRS_OFF_LINE_REV: begin
            rdata_d[`DRS_BIT_CAPABILITY] = line_side_capability; // [R8]
            rdata_d[5:2] = line_side_rev; // [R7]
            rdata_d[`DRS_BIT_RX_GAIN] = rx_gain_q;
            rdata_d[`DRS_BIT_TX_ATTEN] = tx_atten_q;
         end
         default: begin
            rdata_d = 8'h00; // [R13]
         end
      endcase
   end

   // Read data registered, valid only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// >>> src/drs_defines.svh
// Offsets, field positions, reset values and codes of the rate and status registers
`ifndef DRS_DEFINES_SVH
`define DRS_DEFINES_SVH
`define DRS_ADDR_W 4
`define DRS_OFF_RSVD_A 4'h8
`define DRS_OFF_RATE 4'h9
`define DRS_OFF_RSVD_B 4'ha
`define DRS_OFF_SYS_REV 4'hb
`define DRS_OFF_LINE_STAT 4'hc
`define DRS_OFF_LINE_REV 4'hd
`define DRS_RATE_RESET 3'h0
`define DRS_RATE_RSVD_CODE 3'h7
`define DRS_BIT_LINK_ERR 7
`define DRS_BIT_FRAME_LOCK 6
`define DRS_BIT_CAPABILITY 6
`define DRS_BIT_RX_GAIN 1
`define DRS_BIT_TX_ATTEN 0
`define DRS_SENSE_EXC_HI 5'h1e
`define DRS_LOOP_EXC_HI 4'he
`define DRS_SENSE_EXC_LO 5'h01
`define DRS_LOOP_EXC_LO 4'h1
`define DRS_SYS_REV_VALUE 4'h1
`define DRS_IN_SYNC_STAGES 3
`endif

// >>> src/drs_pkg.sv
// Types shared by the rate and status register block
package drs_pkg;
   // Converter sample rate choices
   typedef enum logic [2:0] {
      DRS_RATE_7200,
      DRS_RATE_8000,
      DRS_RATE_8229,
      DRS_RATE_8400,
      DRS_RATE_9000,
      DRS_RATE_9600,
      DRS_RATE_10286,
      DRS_RATE_RSVD
   } drs_rate_t;
endpackage

// >>> src/drs_sync.sv
// Three-stage synchroniser with agreement filter for one outside level
`timescale 1ns/1ps
`include "drs_defines.svh"
module drs_sync (
   input wire logic clk, // Block clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic async_in, // Level from outside the domain
   output logic sync_out // Filtered level
);
   logic [`DRS_IN_SYNC_STAGES-1:0] stage_q; // Capture chain

   // Shift the outside level through the chain
   always_ff @(posedge clk) begin
      if (!resetn) begin
         stage_q <= '0;
      end else begin
         stage_q <= {stage_q[1:0], async_in};
      end
   end

   // Accept a change only once stages two and three agree
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sync_out <= 1'b0;
      end else if (stage_q[1] == stage_q[2]) begin
         sync_out <= stage_q[2];
      end
   end
endmodule

// >>> src/drs_loop_decode.sv
// Loop current decode from the five-bit line sense field
`timescale 1ns/1ps
`include "drs_defines.svh"
module drs_loop_decode (
   input wire logic [4:0] sense, // Line sense field
   input wire logic off_hook, // Line is off-hook
   output logic [3:0] loop_current // Decoded loop current value
);
   // Off-hook applies the two exceptions, on-hook takes the upper bits
   always_comb begin
      loop_current = sense[4:1]; // [R5]
      if (off_hook) begin
         if (sense == `DRS_SENSE_EXC_HI) begin
            loop_current = `DRS_LOOP_EXC_HI; // [R4]
         end else if (sense == `DRS_SENSE_EXC_LO) begin
            loop_current = `DRS_LOOP_EXC_LO; // [R4]
         end
      end
   end
endmodule

// >>> verification/drs_regs_monitor.sv
// Port checks for the rate and status registers
`timescale 1ns/1ps
module drs_regs_monitor #(
   parameter logic [3:0] SYS_REV = 4'h1 // Revision under test
) (
   input wire logic clk, // Clock
   input wire logic resetn, // Reset
   input wire logic [3:0] reg_addr, // Address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write
   input wire logic reg_rd, // Read
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic link_fail, // Fail event
   input wire logic [4:0] line_sense_field, // Sense
   input wire logic off_hook, // Hook
   input wire logic [3:0] line_side_rev, // Line rev
   input wire logic line_side_capability, // Capability
   input wire logic [2:0] rate_select, // Rate
   input wire logic rate_valid, // Rate usable
   input wire logic legacy_rx_gain, // Rx gain
   input wire logic legacy_tx_atten, // Tx atten
   input wire logic link_error // Sticky error
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic clr_wr; // Write of 0 to the error bit
   logic gain_wr; // Write to the legacy gain bits
   assign clr_wr = reg_wr && reg_addr == 4'hc && !reg_wdata[7];
   assign gain_wr = reg_wr && reg_addr == 4'hd;
   // Expected loop current
   function automatic logic [3:0] loop_f(logic [4:0] s, logic oh);
      if (oh && s == 5'h1e) return 4'he;
      if (oh && s == 5'h01) return 4'h1;
      return s[4:1];
   endfunction
   a_rate_code_ok: assert property (rate_valid == (rate_select != 3'h7))
      else $error("rate flag wrong");
   a_rate_read_back: assert property (reg_rd && reg_addr == 4'h9 |=> reg_rdata == {5'h00, rate_select})
      else $error("rate read wrong");
   a_err_sets: assert property (link_fail |-> ##2 link_error)
      else $error("error not set");
   a_err_clear_cause: assert property ($fell(link_error) |-> $past(clr_wr, 2))
      else $error("error cleared");
   a_rsvd_zero: assert property (reg_rd && (reg_addr < 4'h9 || reg_addr == 4'ha || reg_addr > 4'hd)
      |=> reg_rdata == 8'h00)
      else $error("reserved not zero");
   a_sys_rev: assert property (reg_rd && reg_addr == 4'hb |=> reg_rdata == {4'h0, SYS_REV})
      else $error("revision wrong");
   a_status_read: assert property (reg_rd && reg_addr == 4'hc |=> reg_rdata[7] == link_error
      && reg_rdata[5:0] == {2'b00, loop_f($past(line_sense_field), $past(off_hook))})
      else $error("status wrong");
   a_line_rev_read: assert property (reg_rd && reg_addr == 4'hd |=> reg_rdata == {1'b0,
      $past(line_side_capability), $past(line_side_rev), legacy_rx_gain, legacy_tx_atten})
      else $error("line rev wrong");
   a_gain_hold: assert property ($changed({legacy_rx_gain, legacy_tx_atten}) |-> $past(gain_wr, 2))
      else $error("gain moved");
endmodule

// >>> verification/drs_line_model.sv
// Line-side chip: link events, lock level, sense field, identity
`timescale 1ns/1ps
module drs_line_model #(
   parameter logic [3:0] REV = 4'ha, // Arbitrary revision
   parameter logic CAP = 1'b1 // Arbitrary capability
) (
   input wire logic clk, // Clock
   input wire logic fail_req, // Break the link
   input wire logic lock_req, // Hold frame lock
   input wire logic [4:0] sense_req, // Line level
   output logic link_fail = 1'b0, // Fail event
   output logic frame_lock_pin = 1'b0, // Lock level
   output logic [4:0] line_sense_field = 5'h00, // Sense
   output logic [3:0] line_side_rev, // Revision
   output logic line_side_capability // Capability
);
   // Link state moves one cycle behind the request
   always @(posedge clk) begin
      link_fail <= fail_req;
      frame_lock_pin <= lock_req;
      line_sense_field <= sense_req;
   end
   assign line_side_rev = REV;
   assign line_side_capability = CAP;
endmodule

// >>> verification/drs_regs_tb.sv
// Bench for the rate and status registers
`timescale 1ns/1ps
module drs_regs_tb;
   logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, off_hook = 1'b0;
   logic fail_req = 1'b0, lock_req = 1'b0, link_fail, frame_lock_pin, line_side_capability;
   logic [3:0] reg_addr = 4'h0, line_side_rev;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_v;
   logic [4:0] sense_req = 5'h00, line_sense_field;
   logic [2:0] rate_select;
   logic rate_valid, legacy_rx_gain, legacy_tx_atten, link_error;
   int fail_count = 0, cmp_count = 0;
   // Address, write data, read back
   logic [19:0] rows [10] = '{20'h90505, 20'h9ff07, 20'h90000, 20'h8ff00, 20'haff00,
      20'hbff01, 20'heff00, 20'h7ff00, 20'hdff6b, 20'hd0068};
   // Hook, sense, loop current
   logic [9:0] loops [5] = '{10'h3ee, 10'h211, 10'h35a, 10'h1ef, 10'h010};
   drs_regs u_drs_regs (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .link_fail, .frame_lock_pin, .line_sense_field, .off_hook, .line_side_rev,
      .line_side_capability, .rate_select, .rate_valid, .legacy_rx_gain, .legacy_tx_atten,
      .link_error);
   drs_line_model u_drs_line_model (.clk, .fail_req, .lock_req, .sense_req, .link_fail,
      .frame_lock_pin, .line_sense_field, .line_side_rev, .line_side_capability);
   initial forever #20 clk = ~clk;
   task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", n, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(4'h9);
      chk("rate reset", rd_v, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i][19:16], rows[i][15:8]);
         rd(rows[i][19:16]);
         chk("read back", rd_v, rows[i][7:0]);
      end
      wr(4'hd, 8'h02);
      @(posedge clk);
      #1 chk("legacy", {6'h00, legacy_rx_gain, legacy_tx_atten}, 8'h02);
      wr(4'hd, 8'h00);
      for (int c = 0; c < 8; c++) begin
         wr(4'h9, 8'(c));
         @(posedge clk);
         #1 chk("rate out", {rate_valid, 4'h0, rate_select}, {c != 7, 4'h0, 3'(c)});
      end
      @(posedge clk) fail_req <= 1'b1;
      @(posedge clk) fail_req <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         if (k > 0) wr(4'hc, k == 1 ? 8'h80 : 8'h00);
         rd(4'hc);
         chk("link error", rd_v, k < 2 ? 8'h80 : 8'h00);
      end
      foreach (loops[i]) begin
         @(posedge clk);
         lock_req <= 1'b1;
         {off_hook, sense_req} <= loops[i][9:4];
         repeat (6) @(posedge clk);
         rd(4'hc);
         chk("status", rd_v, {4'h4, loops[i][3:0]});
      end
      @(posedge clk) resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(4'h9);
      chk("rate rereset", {rd_v[7:1], link_error}, 8'h00);
      final_report;
   end
   // Watchdog against a hang
   initial begin
      #100000;
      fail_count++;
      final_report;
   end
endmodule
bind drs_regs drs_regs_monitor #(.SYS_REV(SYS_REV)) u_drs_regs_monitor (.clk, .resetn,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_fail, .line_sense_field,
   .off_hook, .line_side_rev, .line_side_capability, .rate_select, .rate_valid,
   .legacy_rx_gain, .legacy_tx_atten, .link_error);
